// ==== hdl/system_watchdog_timer.sv ====
// Function
// RULE1 - Watchdog runs out of every reset without any software action.
// RULE2 - Off and on instructions stop and restart the watchdog at any time. Code: off no longer stops it once overflow has raised the prewarning.
// RULE3 - Software must service the watchdog before the counter overflows.
// RULE4 - Overflow raises a prewarning interrupt first, then a reset request.
// RULE5 - Sixteen-bit counter advanced by system clock divided by 16,384 or 256.
// RULE6 - Counter preset from a software-programmable preset value register.
// RULE7 - Each service loads counter from preset value and clears the prescaler. Code: service does neither once overflow has raised the prewarning.
// RULE8 - Default prescaler and preset give 6.5 ms at 10 MHz.
// RULE9 - Fixed tick delay from prewarning to reset; reset request held until reset.
//
// System watchdog core: counter, preset register and overflow sequencing.
// Assumes instruction strobes are one-cycle pulses on ref_clk.
`timescale 1ns/1ps
`include "watchdog_defs.svh"

module system_watchdog_timer (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        serviceStrobe,
  input  wire logic        watchdogOffInstruction,
  input  wire logic        watchdogOnInstruction,
  input  wire logic        presetWrite,
  input  wire logic [15:0] presetWriteData,
  input  wire logic        prescaleWrite,
  input  wire logic        prescaleWriteData,
  output logic             prewarnIrq,
  output logic             resetRequest,
  output logic [15:0]      counterValue,
  output logic             running
);

  logic                     enable_r;
  logic                     enable_nxt;
  logic [`WDT_CNT_W-1:0]    watchdogPresetValue_r;
  logic [`WDT_CNT_W-1:0]    watchdogPresetValue_nxt;
  logic                     divShort_r;
  logic                     divShort_nxt;
  logic [`WDT_CNT_W-1:0]    cnt_r;
  logic [`WDT_CNT_W-1:0]    cnt_nxt;
  logic [`WDT_WARN_W-1:0]   warn_r;
  logic [`WDT_WARN_W-1:0]   warn_nxt;
  logic                     irq_r;
  logic                     irq_nxt;
  watchdog_pkg::wd_state_type state_r;
  watchdog_pkg::wd_state_type state_nxt;
  logic                     reqRst_r;
  logic                     reqRst_nxt;
  logic                     tick;
  logic                     preRun;
  logic                     preClear;
  logic                     inRun;
  logic                     svcTake;
  logic                     cntTick;
  logic                     overflow;
  logic                     warnDone;

  // ==========================================================
  // Prescaler
  assign preRun   = enable_r || (state_r != watchdog_pkg::WD_RUN);
  assign preClear = serviceStrobe && (state_r == watchdog_pkg::WD_RUN);  // [RULE7]

  watchdog_prescaler u_prescaler (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .run      (preRun),
    .clear    (preClear),
    .divShort (divShort_r),
    .tick     (tick)
  );

  // ==========================================================
  // Events
  assign inRun    = (state_r == watchdog_pkg::WD_RUN);
  assign svcTake  = serviceStrobe && inRun;  // [RULE7]
  assign cntTick  = tick && enable_r && inRun && !serviceStrobe;  // [RULE5]
  assign overflow = cntTick && (cnt_r == `WDT_CNT_MAX);  // [RULE4]
  assign warnDone = tick && (state_r == watchdog_pkg::WD_WARN) && (warn_r == `WDT_WARN_TICKS - 8'h01);  // [RULE9]

  // ==========================================================
  // Enable
  always_comb begin
    enable_nxt = enable_r;
    if (watchdogOffInstruction) begin
      enable_nxt = 1'b0;  // [RULE2]
    end
    if (watchdogOnInstruction) begin
      enable_nxt = 1'b1;  // [RULE2]
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      enable_r <= 1'b1;  // [RULE1]
    end else begin
      enable_r <= enable_nxt;
    end
  end

  // ==========================================================
  // Preset value
  always_comb begin
    watchdogPresetValue_nxt = watchdogPresetValue_r;
    if (presetWrite) begin
      watchdogPresetValue_nxt = presetWriteData;  // [RULE6]
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      watchdogPresetValue_r <= `WDT_DEF_PRESET;  // [RULE8]
    end else begin
      watchdogPresetValue_r <= watchdogPresetValue_nxt;
    end
  end

  // ==========================================================
  // Prescale select
  always_comb begin
    divShort_nxt = divShort_r;
    if (prescaleWrite) begin
      divShort_nxt = prescaleWriteData;  // [RULE5]
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      divShort_r <= `WDT_DEF_PRESCALE;  // [RULE8]
    end else begin
      divShort_r <= divShort_nxt;
    end
  end

  // ==========================================================
  // Overflow sequence
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      watchdog_pkg::WD_RUN: begin
        if (overflow) begin
          state_nxt = watchdog_pkg::WD_WARN;  // [RULE4]
        end
      end
      watchdog_pkg::WD_WARN: begin
        if (warnDone) begin
          state_nxt = watchdog_pkg::WD_RESET;  // [RULE9]
        end
      end
      watchdog_pkg::WD_RESET: begin
        state_nxt = watchdog_pkg::WD_RESET;  // [RULE9]
      end
      default: begin
        state_nxt = watchdog_pkg::WD_RESET;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= watchdog_pkg::WD_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================
  // Counter
  always_comb begin
    cnt_nxt = cnt_r;
    if (svcTake || overflow) begin
      cnt_nxt = watchdogPresetValue_r;  // [RULE7]
    end else if (cntTick) begin
      cnt_nxt = cnt_r + 16'h0001;  // [RULE5]
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= `WDT_DEF_PRESET;  // [RULE1]
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // ==========================================================
  // Prewarning delay
  always_comb begin
    warn_nxt = warn_r;
    if (overflow) begin
      warn_nxt = '0;
    end else if (tick && (state_r == watchdog_pkg::WD_WARN) && !warnDone) begin
      warn_nxt = warn_r + 8'h01;  // [RULE9]
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      warn_r <= '0;
    end else begin
      warn_r <= warn_nxt;
    end
  end

  // ==========================================================
  // Prewarning pulse
  always_comb begin
    irq_nxt = overflow;  // [RULE4]
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  // ==========================================================
  // Reset request
  always_comb begin
    reqRst_nxt = reqRst_r;
    if (warnDone || (state_r == watchdog_pkg::WD_RESET)) begin
      reqRst_nxt = 1'b1;  // [RULE9]
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      reqRst_r <= 1'b0;
    end else begin
      reqRst_r <= reqRst_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign prewarnIrq   = irq_r;
  assign resetRequest = reqRst_r;  // [RULE4]
  assign counterValue = cnt_r;
  assign running      = enable_r;

endmodule

// ==== hdl/watchdog_defs.svh ====
// Timing counts, reset values and widths of the system watchdog.
// Assumes inclusion by bare name from the watchdog design files.
`ifndef WATCHDOG_DEFS_SVH
`define WATCHDOG_DEFS_SVH

// ==========================================================
// Widths
`define WDT_CNT_W        16
`define WDT_PRE_W        14
`define WDT_WARN_W       8

// ==========================================================
// Prescaler terminal values
`define WDT_PRE_LONG_MAX  14'h3FFF
`define WDT_PRE_SHORT_MAX 14'h00FF

// ==========================================================
// Reset defaults: 6.5 ms at 10 MHz = 65,000 cycles, about 254 ticks of 256
`define WDT_DEF_PRESCALE 1'b1
`define WDT_DEF_PRESET   16'hFF02
`define WDT_CNT_MAX      16'hFFFF

// ==========================================================
// Prewarning to reset request, in prescaled ticks
`define WDT_WARN_TICKS   8'h10

`endif

// ==== hdl/watchdog_pkg.sv ====
// Types of the system watchdog.
// Assumes nothing beyond the defs header.
package watchdog_pkg;

  typedef enum logic [2:0] {
    WD_RUN   = 3'b001,
    WD_WARN  = 3'b010,
    WD_RESET = 3'b100
  } wd_state_type;

endpackage

// ==== hdl/watchdog_prescaler.sv ====
// Selectable divide-by-16,384 or divide-by-256 tick divider.
// Assumes one system clock and a synchronous clear from the watchdog core.
`timescale 1ns/1ps
`include "watchdog_defs.svh"

module watchdog_prescaler (
  input  wire logic ref_clk,
  input  wire logic rstn,
  input  wire logic run,
  input  wire logic clear,
  input  wire logic divShort,
  output logic      tick
);

  logic [`WDT_PRE_W-1:0] pre_r;
  logic [`WDT_PRE_W-1:0] pre_nxt;
  logic [`WDT_PRE_W-1:0] preMax;

  // ==========================================================
  // Divider
  always_comb begin
    preMax  = divShort ? `WDT_PRE_SHORT_MAX : `WDT_PRE_LONG_MAX;
    tick    = run && !clear && (pre_r >= preMax);  // [RULE5]
    pre_nxt = pre_r;
    if (clear || tick) begin
      pre_nxt = '0;  // [RULE7]
    end else if (run) begin
      pre_nxt = pre_r + 14'h0001;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_nxt;
    end
  end

endmodule

// ==== testbench/system_watchdog_timer_sva.sv ====
// Port checker of the watchdog core.
// Assumes binding onto system_watchdog_timer.
`timescale 1ns/1ps
module system_watchdog_timer_sva (
  input wire logic        ref_clk,
  input wire logic        rstn,
  input wire logic        serviceStrobe,
  input wire logic        watchdogOffInstruction,
  input wire logic        watchdogOnInstruction,
  input wire logic        presetWrite,
  input wire logic        prescaleWrite,
  input wire logic        prewarnIrq,
  input wire logic        resetRequest,
  input wire logic [15:0] counterValue,
  input wire logic        running
);
  // ==========
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  AST_PULSE: assert property (prewarnIrq |=> !prewarnIrq)
    else $error("prewarn too long");
  AST_FIRST: assert property (prewarnIrq |-> !resetRequest)
    else $error("reset before prewarn");
  AST_OVF: assert property (prewarnIrq |-> $past(counterValue) == 16'hFFFF)
    else $error("prewarn without overflow");
  AST_HOLD: assert property (resetRequest |=> resetRequest)
    else $error("reset request dropped");
  AST_OFF: assert property (watchdogOffInstruction && !watchdogOnInstruction |=> !running)
    else $error("off ignored");
  AST_ON: assert property (watchdogOnInstruction |=> running)
    else $error("on ignored");
  AST_FROZEN: assert property (!running && $past(!running) && !serviceStrobe |=> $stable(counterValue))
    else $error("counter moved while off");
  AST_STEP: assert property (running && !serviceStrobe && !presetWrite && !prescaleWrite |=>
    counterValue - $past(counterValue) <= 16'h0001 || prewarnIrq || resetRequest)
    else $error("counter jump");
endmodule
bind system_watchdog_timer system_watchdog_timer_sva i_sva (.ref_clk(ref_clk), .rstn(rstn),
  .serviceStrobe(serviceStrobe), .watchdogOffInstruction(watchdogOffInstruction),
  .watchdogOnInstruction(watchdogOnInstruction), .presetWrite(presetWrite), .prescaleWrite(prescaleWrite),
  .prewarnIrq(prewarnIrq), .resetRequest(resetRequest), .counterValue(counterValue), .running(running));

// ==== testbench/test_system_watchdog_timer.sv ====
// Self-checking bench of the watchdog core.
// Assumes the defs header on the include path.
`timescale 1ns/1ps
`include "watchdog_defs.svh"
module test_system_watchdog_timer;
  // =========
  // Stimulus
  logic        ref_clk = 0, rstn = 0, svc = 0, off = 0, on = 0, pw = 0, sw = 0, sd = 0;
  logic [15:0] pd = 0, c;
  logic        irq, rq, run;
  logic [15:0] cnt;
  int          n_fail = 0, cmp_count = 0, k, e, dv, p;
  logic [15:0] mCnt, mPreset;
  logic        mEn, mShort, mIrq, mTick;
  int          mPre, mSt, mWarn;
  system_watchdog_timer i_dut (.ref_clk(ref_clk), .rstn(rstn), .serviceStrobe(svc),
    .watchdogOffInstruction(off), .watchdogOnInstruction(on), .presetWrite(pw), .presetWriteData(pd),
    .prescaleWrite(sw), .prescaleWriteData(sd), .prewarnIrq(irq), .resetRequest(rq), .counterValue(cnt),
    .running(run));
  initial forever #12.5 ref_clk = ~ref_clk;
  // =========
  // Model
  always_comb begin
    mTick = (mEn || mSt != 0) && !(svc && mSt == 0) && mPre >= (mShort ? 255 : 16383);
  end
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      mCnt    <= `WDT_DEF_PRESET;
      mPreset <= `WDT_DEF_PRESET;
      mEn     <= 1'b1;
      mShort  <= `WDT_DEF_PRESCALE;
      mIrq    <= 1'b0;
      mPre    <= 0;
      mSt     <= 0;
      mWarn   <= 0;
    end else begin
      mIrq <= mSt == 0 && !svc && mTick && mEn && mCnt == 16'hFFFF;
      if (mTick || (svc && mSt == 0)) mPre <= 0;
      else if (mEn || mSt != 0) mPre <= mPre + 1;
      if (mSt == 0 && svc) mCnt <= mPreset;
      else if (mSt == 0 && mTick && mEn) mCnt <= (mCnt == 16'hFFFF) ? mPreset : mCnt + 16'h0001;
      if (mSt == 0 && !svc && mTick && mEn && mCnt == 16'hFFFF) begin
        mSt   <= 1;
        mWarn <= 0;
      end else if (mSt == 1 && mTick) begin
        mWarn <= mWarn + 1;
        if (mWarn == `WDT_WARN_TICKS - 1) mSt <= 2;
      end
      if (on) mEn <= 1'b1;
      else if (off) mEn <= 1'b0;
      if (pw) mPreset <= pd;
      if (sw) mShort <= sd;
    end
  end
  always @(negedge ref_clk) begin
    if (rstn) begin
      check(cnt, mCnt);
      check(irq, mIrq);
      check(rq, mSt == 2);
      check(run, mEn);
    end
  end
  task automatic cyc(int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic check(logic [15:0] s, logic [15:0] x);
    cmp_count++;
    if (s !== x) begin
      n_fail++;
      $display("CHECK FAILED %0t seen %h exp %h", $time, s, x);
    end
  endtask
  task automatic wait_for(bit w, output int n);
    n = 0;
    while ((w ? rq : irq) !== 1'b1 && n < 70000) begin
      cyc(1);
      n++;
    end
    if (n >= 70000) begin
      n_fail++;
      wrap_up();
    end
  endtask
  task automatic wrap_up();
    $display("fails %0d checks %0d", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    void'($urandom(58674));
    cyc(5);
    for (int i = 0; i < 3; i++) begin
      rstn = 0;
      cyc(2);
      rstn = 1;
      cyc(1);
      check(cnt, `WDT_DEF_PRESET);
      check(run, 1);
      if (i == 0) begin
        k = 1;
        while (cnt === `WDT_DEF_PRESET && k < 1000) begin
          cyc(1);
          k++;
        end
        check(k * (65536 - `WDT_DEF_PRESET) >= 64500 && k * (65536 - `WDT_DEF_PRESET) <= 65500, 1);
        if (k >= 1000) wrap_up();
      end
      dv = (i < 2) ? 256 : 16384;
      p = (i < 2) ? 16'hFFF0 + $urandom % 15 : 16'hFFFF;
      sd = (i < 2);
      sw = 1;
      pd = p[15:0];
      pw = 1;
      cyc(1);
      sw = 0;
      pw = 0;
      svc = 1;
      cyc(1);
      svc = 0;
      check(cnt, pd);
      cyc(50);
      svc = 1;
      cyc(1);
      svc = 0;
      e = (65536 - p) * dv;
      if (i == 1) begin
        cyc(40);
        off = 1;
        cyc(1);
        off = 0;
        c = cnt;
        cyc(500);
        check(cnt, c);
        check(run, 0);
        on = 1;
        cyc(1);
        on = 0;
        e = e - 41;
      end
      wait_for(0, k);
      check(k >= e - 3 && k <= e + 3, 1);
      check(cnt, pd);
      check(rq, 0);
      svc = 1;
      cyc(1);
      svc = 0;
      if (i < 2) begin
        wait_for(1, k);
        check(k >= 16 * dv - 4 && k <= 16 * dv + 3, 1);
        cyc(3);
        check(rq, 1);
      end
    end
    wrap_up();
  end
endmodule
